// >>> rtl/cftim_map.vh
// constants for the control-flow and exception cycle timing model
`ifndef CFTIM_MAP_VH
`define CFTIM_MAP_VH

// ****************************************
// operation codes
// ****************************************
`define CFTIM_OP_W 5
`define CFTIM_OP_BR_TAKEN 5'h00
`define CFTIM_OP_BR_BYTE_NT 5'h01
`define CFTIM_OP_BR_WORD_NT 5'h02
`define CFTIM_OP_BR_LONG_NT 5'h03
`define CFTIM_OP_LOOP_RUN 5'h04
`define CFTIM_OP_LOOP_EXPIRED 5'h05
`define CFTIM_OP_LOOP_CC_TRUE 5'h06
`define CFTIM_OP_SWAP_OK 5'h07
`define CFTIM_OP_SWAP_FAIL 5'h08
`define CFTIM_OP_SWAP_DUAL_OK 5'h09
`define CFTIM_OP_SWAP_DUAL_FAIL 5'h0A
`define CFTIM_OP_REG_BOUNDS_EXC 5'h0B
`define CFTIM_OP_MEM_BOUNDS_EXC 5'h0C
`define CFTIM_OP_UNCOND_JUMP 5'h0D
`define CFTIM_OP_JUMP_SUB 5'h0E
`define CFTIM_OP_SW_TRAP 5'h0F
`define CFTIM_OP_ILLEGAL 5'h10
`define CFTIM_OP_LINE_A 5'h11
`define CFTIM_OP_LINE_F 5'h12
`define CFTIM_OP_PRIV_VIOL 5'h13
`define CFTIM_OP_INT_ISTACK 5'h14
`define CFTIM_OP_INT_MSTACK 5'h15
`define CFTIM_OP_FAULT_SHORT 5'h16
`define CFTIM_OP_FAULT_LONG 5'h17
`define CFTIM_OP_RET_FOUR 5'h18
`define CFTIM_OP_RET_SIX 5'h19
`define CFTIM_OP_RET_THROW 5'h1A
`define CFTIM_OP_RET_COPROC 5'h1B
`define CFTIM_OP_RET_LONG 5'h1C

// ****************************************
// table entry layout: valid, total, reads, prefetches, writes
// ****************************************
`define CFTIM_ENT_W 20
`define CFTIM_ENT_VALID 19
`define CFTIM_ENT_TOT_HI 18
`define CFTIM_ENT_TOT_LO 12
`define CFTIM_ENT_RD_HI 11
`define CFTIM_ENT_RD_LO 7
`define CFTIM_ENT_PF_HI 6
`define CFTIM_ENT_PF_LO 5
`define CFTIM_ENT_WR_HI 4
`define CFTIM_ENT_WR_LO 0
`define CFTIM_ENT_NONE 20'h00000

// ****************************************
// sequencer states, access kinds, bus timing
// ****************************************
`define CFTIM_ST_IDLE 2'h0
`define CFTIM_ST_LOOKUP 2'h1
`define CFTIM_ST_RUN 2'h2
`define CFTIM_KIND_NONE 2'h0
`define CFTIM_KIND_RD 2'h1
`define CFTIM_KIND_PF 2'h2
`define CFTIM_KIND_WR 2'h3
`define CFTIM_BUS_CLKS_LOG2 1
`define CFTIM_CNT_W 9
`define CFTIM_ONE 9'h001
`define CFTIM_ZERO 9'h000

`endif

// >>> rtl/cftim_rom.v
// timing table: cached and uncached entries per operation, registered read
`timescale 1ns/1ps

`include "cftim_map.vh"

module cftim_rom (
    input wire clk,
    input wire rst,
    input wire [`CFTIM_OP_W-1:0] addr,
    output reg [`CFTIM_ENT_W-1:0] hit_data,
    output reg [`CFTIM_ENT_W-1:0] miss_data
);

    reg [`CFTIM_ENT_W-1:0] hit_nxt;
    reg [`CFTIM_ENT_W-1:0] miss_nxt;

    // ****************************************
    // table: {valid, total, reads, prefetches, writes}
    // ****************************************
    always @* begin
        case (addr)
            `CFTIM_OP_BR_TAKEN: begin
                hit_nxt = {1'h1, 7'h06, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h08, 5'h00, 2'h2, 5'h00};
            end
            `CFTIM_OP_BR_BYTE_NT: begin
                hit_nxt = {1'h1, 7'h04, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h04, 5'h00, 2'h1, 5'h00};
            end
            `CFTIM_OP_BR_WORD_NT: begin
                hit_nxt = {1'h1, 7'h06, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h06, 5'h00, 2'h1, 5'h00};
            end
            `CFTIM_OP_BR_LONG_NT: begin
                hit_nxt = {1'h1, 7'h06, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h08, 5'h00, 2'h2, 5'h00};
            end
            `CFTIM_OP_LOOP_RUN: begin
                hit_nxt = {1'h1, 7'h06, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h08, 5'h00, 2'h2, 5'h00};
            end
            `CFTIM_OP_LOOP_EXPIRED: begin
                hit_nxt = {1'h1, 7'h0A, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h0D, 5'h00, 2'h3, 5'h00};
            end
            `CFTIM_OP_LOOP_CC_TRUE: begin
                hit_nxt = {1'h1, 7'h06, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h08, 5'h00, 2'h1, 5'h00};
            end
            `CFTIM_OP_SWAP_OK: begin
                hit_nxt = {1'h1, 7'h0D, 5'h01, 2'h0, 5'h01};
                miss_nxt = {1'h1, 7'h0D, 5'h01, 2'h1, 5'h01};
            end
            `CFTIM_OP_SWAP_FAIL: begin
                hit_nxt = {1'h1, 7'h0B, 5'h01, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h0B, 5'h01, 2'h1, 5'h00};
            end
            // worst-case figures used as the exact count
            `CFTIM_OP_SWAP_DUAL_OK: begin
                hit_nxt = {1'h1, 7'h18, 5'h02, 2'h0, 5'h02};
                miss_nxt = {1'h1, 7'h1A, 5'h02, 2'h2, 5'h02};
            end
            `CFTIM_OP_SWAP_DUAL_FAIL: begin
                hit_nxt = {1'h1, 7'h18, 5'h02, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h18, 5'h02, 2'h2, 5'h00};
            end
            `CFTIM_OP_REG_BOUNDS_EXC: begin
                hit_nxt = {1'h1, 7'h1C, 5'h01, 2'h0, 5'h04};
                miss_nxt = {1'h1, 7'h1E, 5'h01, 2'h3, 5'h04};
            end
            `CFTIM_OP_MEM_BOUNDS_EXC: begin
                hit_nxt = {1'h1, 7'h28, 5'h02, 2'h0, 5'h04};
                miss_nxt = {1'h1, 7'h2A, 5'h02, 2'h3, 5'h04};
            end
            `CFTIM_OP_UNCOND_JUMP: begin
                hit_nxt = {1'h1, 7'h04, 5'h00, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h06, 5'h00, 2'h2, 5'h00};
            end
            `CFTIM_OP_JUMP_SUB: begin
                hit_nxt = {1'h1, 7'h04, 5'h00, 2'h0, 5'h01};
                miss_nxt = {1'h1, 7'h07, 5'h00, 2'h2, 5'h01};
            end
            `CFTIM_OP_SW_TRAP, `CFTIM_OP_ILLEGAL, `CFTIM_OP_LINE_A, `CFTIM_OP_LINE_F,
            `CFTIM_OP_PRIV_VIOL: begin
                hit_nxt = {1'h1, 7'h12, 5'h01, 2'h0, 5'h04};
                miss_nxt = {1'h1, 7'h14, 5'h01, 2'h2, 5'h04};
            end
            `CFTIM_OP_INT_ISTACK: begin
                hit_nxt = {1'h1, 7'h17, 5'h02, 2'h0, 5'h04};
                miss_nxt = {1'h1, 7'h18, 5'h02, 2'h2, 5'h04};
            end
            `CFTIM_OP_INT_MSTACK: begin
                hit_nxt = {1'h1, 7'h21, 5'h02, 2'h0, 5'h08};
                miss_nxt = {1'h1, 7'h22, 5'h02, 2'h2, 5'h08};
            end
            `CFTIM_OP_FAULT_SHORT: begin
                hit_nxt = {1'h1, 7'h24, 5'h01, 2'h0, 5'h0A};
                miss_nxt = {1'h1, 7'h26, 5'h01, 2'h2, 5'h0A};
            end
            `CFTIM_OP_FAULT_LONG: begin
                hit_nxt = {1'h1, 7'h3E, 5'h01, 2'h0, 5'h18};
                miss_nxt = {1'h1, 7'h40, 5'h01, 2'h2, 5'h18};
            end
            `CFTIM_OP_RET_FOUR, `CFTIM_OP_RET_SIX: begin
                hit_nxt = {1'h1, 7'h12, 5'h04, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h14, 5'h04, 2'h2, 5'h00};
            end
            `CFTIM_OP_RET_THROW: begin
                hit_nxt = {1'h1, 7'h0C, 5'h04, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h0C, 5'h04, 2'h0, 5'h00};
            end
            `CFTIM_OP_RET_COPROC: begin
                hit_nxt = {1'h1, 7'h1A, 5'h07, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h1A, 5'h07, 2'h2, 5'h00};
            end
            `CFTIM_OP_RET_LONG: begin
                hit_nxt = {1'h1, 7'h4C, 5'h19, 2'h0, 5'h00};
                miss_nxt = {1'h1, 7'h4C, 5'h19, 2'h2, 5'h00};
            end
            default: begin
                hit_nxt = `CFTIM_ENT_NONE;
                miss_nxt = `CFTIM_ENT_NONE;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_data <= `CFTIM_ENT_NONE;
            miss_data <= `CFTIM_ENT_NONE;
        end else begin
            hit_data <= hit_nxt;
            miss_data <= miss_nxt;
        end
    end

endmodule

// >>> rtl/cftim_core.v
// cycle sequencer for branches, control transfers, exception entry and return
`timescale 1ns/1ps

`include "cftim_map.vh"

// Behaviour
// - every bus read, prefetch and write lasts exactly two clocks
// - bus cycles lie inside the total; none run past it
// - branch taken 6/8 clocks; not taken byte/word/long 4,6,6 cached, 4,6,8 uncached
// - loop not expired 6/8 two prefetches; condition true 6/8 one prefetch
// - loop expired 10 cached, 13 uncached with three prefetches
// - single swap 13 clocks success, 11 failure, plus address time
// - dual swap and taken bounds checks never exceed listed maximum counts
// - jump 4/6, subroutine jump 4/7 with stack write, plus address time
// - software, illegal, line and privilege traps 18/20, one read, four writes
// - interrupt 23/24 four writes, master stack 33/34 eight writes
// - short fault frame stacking 36/38 with ten writes
// - long fault frame stacking 62/64 with twenty-four writes
// - exception return four or six word frame 18/20, four reads
// - exception return throwaway 12, coprocessor 26, long fault 76
module cftim_core (
    CLK_SYS,
    RST,
    OP_START,
    OP_CODE,
    CACHE_HIT,
    EA_CLOCKS,
    BUSY,
    DONE,
    OP_ERROR,
    BUS_READ,
    BUS_PREFETCH,
    BUS_WRITE,
    BUS_LAST_CLK,
    TOTAL_CLOCKS
);
    parameter EA_W = 8;

    input wire CLK_SYS;
    input wire RST;
    input wire OP_START;
    input wire [`CFTIM_OP_W-1:0] OP_CODE;
    input wire CACHE_HIT;
    input wire [EA_W-1:0] EA_CLOCKS;
    output reg BUSY;
    output reg DONE;
    output reg OP_ERROR;
    output reg BUS_READ;
    output reg BUS_PREFETCH;
    output reg BUS_WRITE;
    output reg BUS_LAST_CLK;
    output reg [`CFTIM_CNT_W-1:0] TOTAL_CLOCKS;

    // ****************************************
    // state
    // ****************************************
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`CFTIM_CNT_W-1:0] k_r;
    reg [`CFTIM_CNT_W-1:0] k_nxt;
    reg [`CFTIM_CNT_W-1:0] tot_r;
    reg [`CFTIM_CNT_W-1:0] tot_nxt;
    reg [`CFTIM_CNT_W-1:0] ea_r;
    reg [`CFTIM_CNT_W-1:0] ea_nxt;
    reg hit_r;
    reg [4:0] nr_r;
    reg [4:0] nr_nxt;
    reg [1:0] np_r;
    reg [1:0] np_nxt;
    reg [4:0] nw_r;
    reg [4:0] nw_nxt;
    reg [1:0] kind_nxt;
    reg last_nxt;
    reg done_nxt;
    reg err_nxt;
    reg [`CFTIM_ENT_W-1:0] ent;

    wire [`CFTIM_ENT_W-1:0] rom_hit;
    wire [`CFTIM_ENT_W-1:0] rom_miss;

    // keeps the opcode stable toward the table while it is read
    reg [`CFTIM_OP_W-1:0] op_r;
    // idle reads the incoming code so the entry is ready one clock after the take
    wire [`CFTIM_OP_W-1:0] rom_addr;

    assign rom_addr = (state_r == `CFTIM_ST_IDLE) ? OP_CODE : op_r;

    // ****************************************
    // timing table
    // ****************************************
    cftim_rom u_rom (
        .clk(CLK_SYS),
        .rst(RST),
        .addr(rom_addr),
        .hit_data(rom_hit),
        .miss_data(rom_miss)
    );

    // ****************************************
    // access decode
    // ****************************************
    // accesses follow the address time in the order reads, prefetches, writes
    function [1:0] access_kind;
        input [`CFTIM_CNT_W-1:0] k;
        input [`CFTIM_CNT_W-1:0] ea;
        input [4:0] nr;
        input [1:0] np;
        input [4:0] nw;
        reg [`CFTIM_CNT_W-1:0] j;
        begin
            j = (k - ea) >> `CFTIM_BUS_CLKS_LOG2;
            if (k < ea) begin
                access_kind = `CFTIM_KIND_NONE;
            end else if (j < {4'h0, nr}) begin
                access_kind = `CFTIM_KIND_RD;
            end else if (j < ({4'h0, nr} + {7'h00, np})) begin
                access_kind = `CFTIM_KIND_PF;
            end else if (j < ({4'h0, nr} + {7'h00, np} + {4'h0, nw})) begin
                access_kind = `CFTIM_KIND_WR;
            end else begin
                access_kind = `CFTIM_KIND_NONE;
            end
        end
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always @* begin
        state_nxt = state_r;
        k_nxt = k_r;
        tot_nxt = tot_r;
        ea_nxt = ea_r;
        nr_nxt = nr_r;
        np_nxt = np_r;
        nw_nxt = nw_r;
        done_nxt = 1'b0;
        err_nxt = 1'b0;
        ent = hit_r ? rom_hit : rom_miss;
        case (state_r)
            `CFTIM_ST_IDLE: begin
                // a start while busy is ignored
                if (OP_START) begin
                    state_nxt = `CFTIM_ST_LOOKUP;
                    ea_nxt = {{(`CFTIM_CNT_W - EA_W){1'b0}}, EA_CLOCKS};
                end
            end
            `CFTIM_ST_LOOKUP: begin
                if (!ent[`CFTIM_ENT_VALID]) begin
                    state_nxt = `CFTIM_ST_IDLE;
                    err_nxt = 1'b1;
                    done_nxt = 1'b1;
                    tot_nxt = `CFTIM_ZERO;
                end else begin
                    state_nxt = `CFTIM_ST_RUN;
                    k_nxt = `CFTIM_ZERO;
                    // address time added on top of the table total
                    tot_nxt = ea_r + {2'h0, ent[`CFTIM_ENT_TOT_HI:`CFTIM_ENT_TOT_LO]};
                    nr_nxt = ent[`CFTIM_ENT_RD_HI:`CFTIM_ENT_RD_LO];
                    np_nxt = ent[`CFTIM_ENT_PF_HI:`CFTIM_ENT_PF_LO];
                    nw_nxt = ent[`CFTIM_ENT_WR_HI:`CFTIM_ENT_WR_LO];
                end
            end
            `CFTIM_ST_RUN: begin
                // ends on the total, bus cycles already inside it
                if (k_r == tot_r - `CFTIM_ONE) begin
                    state_nxt = `CFTIM_ST_IDLE;
                    done_nxt = 1'b1;
                end else begin
                    k_nxt = k_r + `CFTIM_ONE;
                end
            end
            default: begin
                state_nxt = `CFTIM_ST_IDLE;
            end
        endcase
        // two clocks per access, bit 0 of the offset marks the second
        if (state_nxt == `CFTIM_ST_RUN) begin
            kind_nxt = access_kind(k_nxt, ea_nxt, nr_nxt, np_nxt, nw_nxt);
        end else begin
            kind_nxt = `CFTIM_KIND_NONE;
        end
        last_nxt = (kind_nxt != `CFTIM_KIND_NONE) && ((k_nxt - ea_nxt) & `CFTIM_ONE) == `CFTIM_ONE;
    end

    // ****************************************
    // registers and outputs
    // ****************************************
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_r <= `CFTIM_ST_IDLE;
            k_r <= `CFTIM_ZERO;
            tot_r <= `CFTIM_ZERO;
            ea_r <= `CFTIM_ZERO;
            nr_r <= 5'h00;
            np_r <= 2'h0;
            nw_r <= 5'h00;
            hit_r <= 1'b0;
            op_r <= `CFTIM_OP_BR_TAKEN;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            OP_ERROR <= 1'b0;
            BUS_READ <= 1'b0;
            BUS_PREFETCH <= 1'b0;
            BUS_WRITE <= 1'b0;
            BUS_LAST_CLK <= 1'b0;
            TOTAL_CLOCKS <= `CFTIM_ZERO;
        end else begin
            state_r <= state_nxt;
            k_r <= k_nxt;
            tot_r <= tot_nxt;
            ea_r <= ea_nxt;
            nr_r <= nr_nxt;
            np_r <= np_nxt;
            nw_r <= nw_nxt;
            if (state_r == `CFTIM_ST_IDLE && OP_START) begin
                hit_r <= CACHE_HIT;
                op_r <= OP_CODE;
            end
            BUSY <= (state_nxt != `CFTIM_ST_IDLE);
            DONE <= done_nxt;
            OP_ERROR <= err_nxt;
            BUS_READ <= (kind_nxt == `CFTIM_KIND_RD);
            BUS_PREFETCH <= (kind_nxt == `CFTIM_KIND_PF);
            BUS_WRITE <= (kind_nxt == `CFTIM_KIND_WR);
            BUS_LAST_CLK <= last_nxt;
            // result holds until the next operation completes
            if (done_nxt) begin
                TOTAL_CLOCKS <= tot_nxt;
            end
        end
    end

endmodule

// >>> bench/cftim_mem_model.sv
// memory side of the processor bus: tallies completed reads, prefetches and writes
`timescale 1ns/1ps
module cftim_mem_model (
    input wire clk,
    input wire rst,
    input wire clr,
    input wire rd,
    input wire pf,
    input wire wr,
    input wire last,
    output reg [7:0] cnt_rd_r,
    output reg [7:0] cnt_pf_r,
    output reg [7:0] cnt_wr_r
);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_rd_r <= 8'h00;
            cnt_pf_r <= 8'h00;
            cnt_wr_r <= 8'h00;
        end else if (clr) begin
            cnt_rd_r <= 8'h00;
            cnt_pf_r <= 8'h00;
            cnt_wr_r <= 8'h00;
        end else if (last) begin
            // only the closing clock counts, so a stretched access is not seen twice
            cnt_rd_r <= cnt_rd_r + {7'h00, rd};
            cnt_pf_r <= cnt_pf_r + {7'h00, pf};
            cnt_wr_r <= cnt_wr_r + {7'h00, wr};
        end
    end
endmodule

// >>> bench/cftim_core_asserts.sv
// concurrent checks on the cycle timing core ports
`timescale 1ns/1ps
`include "cftim_map.vh"
module cftim_core_asserts #(parameter EA_W = 8) (
    input wire CLK_SYS,
    input wire RST,
    input wire OP_START,
    input wire [`CFTIM_OP_W-1:0] OP_CODE,
    input wire CACHE_HIT,
    input wire [EA_W-1:0] EA_CLOCKS,
    input wire BUSY,
    input wire DONE,
    input wire OP_ERROR,
    input wire BUS_READ,
    input wire BUS_PREFETCH,
    input wire BUS_WRITE,
    input wire BUS_LAST_CLK,
    input wire [`CFTIM_CNT_W-1:0] TOTAL_CLOCKS
);
    reg hit_r;
    reg [9:0] busy_cnt_r;
    // busy_cnt_r holds the busy cycles of the operation now finishing
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            hit_r <= 1'b0;
            busy_cnt_r <= 10'h000;
        end else begin
            if (OP_START && !BUSY)
                hit_r <= CACHE_HIT;
            if (DONE)
                busy_cnt_r <= 10'h000;
            else if (BUSY)
                busy_cnt_r <= busy_cnt_r + 10'h001;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_read_two_clk: assert property (BUS_READ && !BUS_LAST_CLK |=> BUS_READ && BUS_LAST_CLK)
        else $error("read access not two clocks");
    a_write_two_clk: assert property (BUS_WRITE && !BUS_LAST_CLK |=> BUS_WRITE && BUS_LAST_CLK)
        else $error("write access not two clocks");
    a_last_clk_pair: assert property (BUS_LAST_CLK |-> !$past(BUS_LAST_CLK) && ($past(BUS_READ) && BUS_READ
        || $past(BUS_PREFETCH) && BUS_PREFETCH || $past(BUS_WRITE) && BUS_WRITE))
        else $error("last clock without a first clock");
    a_bus_in_run: assert property ((BUS_READ || BUS_PREFETCH || BUS_WRITE) |-> BUSY && !DONE)
        else $error("bus access outside the operation");
    a_one_access_kind: assert property ($onehot0({BUS_READ, BUS_PREFETCH, BUS_WRITE}))
        else $error("two access kinds at once");
    a_done_single: assert property (DONE |=> !DONE && !OP_ERROR)
        else $error("done longer than one cycle");
    a_done_ends_busy: assert property (DONE |-> !BUSY && $past(BUSY))
        else $error("done without busy before it");
    a_total_count: assert property (DONE |-> busy_cnt_r == {1'b0, TOTAL_CLOCKS} + 10'h001)
        else $error("total differs from busy span");
    a_total_held: assert property (!DONE |-> $stable(TOTAL_CLOCKS))
        else $error("total changed without done");
    a_start_taken: assert property (OP_START && !BUSY |-> ##2 (BUSY || DONE))
        else $error("start not taken");
    a_cached_no_fetch: assert property (BUS_PREFETCH |-> !hit_r)
        else $error("prefetch on a cache hit");
    a_error_zero_total: assert property (OP_ERROR |-> DONE && TOTAL_CLOCKS == 9'h000)
        else $error("error without done or zero total");
endmodule

bind cftim_core cftim_core_asserts #(.EA_W(EA_W)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .OP_START(OP_START),
    .OP_CODE(OP_CODE), .CACHE_HIT(CACHE_HIT), .EA_CLOCKS(EA_CLOCKS), .BUSY(BUSY), .DONE(DONE),
    .OP_ERROR(OP_ERROR), .BUS_READ(BUS_READ), .BUS_PREFETCH(BUS_PREFETCH), .BUS_WRITE(BUS_WRITE),
    .BUS_LAST_CLK(BUS_LAST_CLK), .TOTAL_CLOCKS(TOTAL_CLOCKS));

// >>> bench/tb.sv
// self-checking bench for the cycle timing core
`timescale 1ns/1ps
`include "cftim_map.vh"
module tb;
    reg CLK_SYS = 1'b0;
    reg RST = 1'b1;
    reg OP_START = 1'b0;
    reg [4:0] OP_CODE = 5'h00;
    reg CACHE_HIT = 1'b0;
    reg [7:0] EA_CLOCKS = 8'h00;
    reg clr = 1'b0;
    wire BUSY, DONE, OP_ERROR, BUS_READ, BUS_PREFETCH, BUS_WRITE, BUS_LAST_CLK;
    wire [8:0] TOTAL_CLOCKS;
    wire [7:0] cnt_rd, cnt_pf, cnt_wr;
    integer n_errors = 0;
    integer cmp_count = 0;

    always #20 CLK_SYS = ~CLK_SYS;

    cftim_core #(.EA_W(8)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .OP_START(OP_START), .OP_CODE(OP_CODE),
        .CACHE_HIT(CACHE_HIT), .EA_CLOCKS(EA_CLOCKS), .BUSY(BUSY), .DONE(DONE), .OP_ERROR(OP_ERROR),
        .BUS_READ(BUS_READ), .BUS_PREFETCH(BUS_PREFETCH), .BUS_WRITE(BUS_WRITE),
        .BUS_LAST_CLK(BUS_LAST_CLK), .TOTAL_CLOCKS(TOTAL_CLOCKS));
    cftim_mem_model mem (.clk(CLK_SYS), .rst(RST), .clr(clr), .rd(BUS_READ), .pf(BUS_PREFETCH),
        .wr(BUS_WRITE), .last(BUS_LAST_CLK), .cnt_rd_r(cnt_rd), .cnt_pf_r(cnt_pf), .cnt_wr_r(cnt_wr));

    // ****************************************
    // shared helpers
    // ****************************************
    task check(input [31:0] seen, input [31:0] expd, input [8*16-1:0] what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== expd) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: %0s seen %h expected %h", $time, what, seen, expd);
            end
        end
    endtask

    // packed as total, reads, prefetches, writes; zero means no entry
    function [31:0] expect_of(input [4:0] c, input h);
        case (c)
            5'h00, 5'h03, 5'h04: expect_of = h ? 32'h06000000 : 32'h08000200;
            5'h01: expect_of = h ? 32'h04000000 : 32'h04000100;
            5'h02: expect_of = h ? 32'h06000000 : 32'h06000100;
            5'h05: expect_of = h ? 32'h0A000000 : 32'h0D000300;
            5'h06: expect_of = h ? 32'h06000000 : 32'h08000100;
            5'h07: expect_of = h ? 32'h0D010001 : 32'h0D010101;
            5'h08: expect_of = h ? 32'h0B010000 : 32'h0B010100;
            5'h09: expect_of = h ? 32'h18020002 : 32'h1A020202;
            5'h0A: expect_of = h ? 32'h18020000 : 32'h18020200;
            5'h0B: expect_of = h ? 32'h1C010004 : 32'h1E010304;
            5'h0C: expect_of = h ? 32'h28020004 : 32'h2A020304;
            5'h0D: expect_of = h ? 32'h04000000 : 32'h06000200;
            5'h0E: expect_of = h ? 32'h04000001 : 32'h07000201;
            5'h0F, 5'h10, 5'h11, 5'h12, 5'h13: expect_of = h ? 32'h12010004 : 32'h14010204;
            5'h14: expect_of = h ? 32'h17020004 : 32'h18020204;
            5'h15: expect_of = h ? 32'h21020008 : 32'h22020208;
            5'h16: expect_of = h ? 32'h2401000A : 32'h2601020A;
            5'h17: expect_of = h ? 32'h3E010018 : 32'h40010218;
            5'h18, 5'h19: expect_of = h ? 32'h12040000 : 32'h14040200;
            5'h1A: expect_of = 32'h0C040000;
            5'h1B: expect_of = h ? 32'h1A070000 : 32'h1A070200;
            5'h1C: expect_of = h ? 32'h4C190000 : 32'h4C190200;
            default: expect_of = 32'h00000000;
        endcase
    endfunction

    task wait_done(output integer n);
        begin
            n = 0;
            do begin
                @(posedge CLK_SYS);
                #1;
                n = n + 1;
            end while (DONE !== 1'b1 && n < 400);
        end
    endtask

    task run_op(input [4:0] c, input h, input [7:0] ea);
        reg [31:0] e;
        reg [8:0] t;
        integer n;
        begin
            e = expect_of(c, h);
            t = (e == 32'h0) ? 9'h000 : {1'b0, e[31:24]} + {1'b0, ea};
            @(posedge CLK_SYS);
            OP_START <= 1'b1;
            OP_CODE <= c;
            CACHE_HIT <= h;
            EA_CLOCKS <= ea;
            clr <= 1'b1;
            @(posedge CLK_SYS);
            OP_START <= 1'b0;
            clr <= 1'b0;
            wait_done(n);
            check(n, {23'h000000, t} + 32'h1, "done edge");
            check({23'h000000, TOTAL_CLOCKS}, {23'h000000, t}, "total");
            check({31'h0, OP_ERROR}, {31'h0, e == 32'h0}, "error flag");
            check({8'h00, cnt_rd, cnt_pf, cnt_wr}, {8'h00, e[23:0]}, "bus counts");
        end
    endtask

    task sweep(input [4:0] lo, input [4:0] hi, input [7:0] ea);
        reg [5:0] c;
        begin
            for (c = {1'b0, lo}; c <= {1'b0, hi}; c = c + 6'h01) begin
                run_op(c[4:0], 1'b1, ea);
                run_op(c[4:0], 1'b0, ea);
            end
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task test_branches;
        begin
            sweep(5'h00, 5'h06, 8'h00);
            $display("test_branches finished");
        end
    endtask

    task test_control;
        begin
            sweep(5'h07, 5'h0E, 8'h03);
            run_op(5'h0D, 1'b0, 8'hFF);
            $display("test_control finished");
        end
    endtask

    task test_exceptions;
        begin
            sweep(5'h0F, 5'h17, 8'h00);
            $display("test_exceptions finished");
        end
    endtask

    task test_returns;
        begin
            sweep(5'h18, 5'h1C, 8'h00);
            run_op(5'h1D, 1'b1, 8'h00);
            run_op(5'h1F, 1'b0, 8'h00);
            $display("test_returns finished");
        end
    endtask

    // start held high: the code change while busy waits for the next take
    task test_back_to_back;
        integer n;
        begin
            @(posedge CLK_SYS);
            OP_START <= 1'b1;
            OP_CODE <= 5'h01;
            CACHE_HIT <= 1'b1;
            EA_CLOCKS <= 8'h00;
            repeat (3) @(posedge CLK_SYS);
            OP_CODE <= 5'h05;
            wait_done(n);
            check({23'h000000, TOTAL_CLOCKS}, 32'h4, "first total");
            wait_done(n);
            check(n, 32'hC, "restart spacing");
            check({23'h000000, TOTAL_CLOCKS}, 32'hA, "second total");
            @(posedge CLK_SYS);
            OP_START <= 1'b0;
            wait_done(n);
            $display("test_back_to_back finished");
        end
    endtask

    task test_reset;
        begin
            @(posedge CLK_SYS);
            OP_START <= 1'b1;
            OP_CODE <= 5'h1C;
            CACHE_HIT <= 1'b0;
            @(posedge CLK_SYS);
            OP_START <= 1'b0;
            repeat (20) @(posedge CLK_SYS);
            RST <= 1'b1;
            @(posedge CLK_SYS);
            #1;
            check({16'h0000, BUSY, DONE, OP_ERROR, BUS_READ, BUS_PREFETCH, BUS_WRITE, BUS_LAST_CLK,
                TOTAL_CLOCKS}, 32'h0, "outputs in reset");
            @(posedge CLK_SYS);
            RST <= 1'b0;
            run_op(5'h0E, 1'b0, 8'h00);
            $display("test_reset finished");
        end
    endtask

    // ****************************************
    // sequence and verdict
    // ****************************************
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        test_branches;
        test_control;
        test_exceptions;
        test_back_to_back;
        test_returns;
        test_reset;
        give_verdict;
    end

    // about 1800 cycles expected; a hang is cut well beyond that
    initial begin
        #400000;
        n_errors = n_errors + 1;
        give_verdict;
    end
endmodule
